// >>> dv/cx_exec_props.sv
// assertion checker for the execution unit
module cx_exec_props
   import cx_pkg::*;
(
   input wire logic               clk_sys,
   input wire logic               sys_rst,
   input wire logic               instValid,
   input wire cx_instr_t          instr,
   input wire logic               instReady,
   input wire logic [DATA_W-1:0]  fileRdData,
   input wire cx_file_wr_t        fileWr,
   input wire logic [DATA_W-1:0]  workRegister,
   input wire logic               zeroFlag,
   input wire logic               carryFlag,
   input wire logic [CNT_W-1:0]   programCounter,
   input wire logic [LATCH_W-1:0] programCounterHighLatch
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic   tk, ex, skipQ;
   cx_op_t op;
   assign tk = instValid && instReady;
   assign op = instr.op;
   assign ex = tk && !skipQ;
   always_ff @(posedge clk_sys)
      if (sys_rst) skipQ <= 1'b0;
      else if (tk) skipQ <= ex && op == OP_INCREMENT_SKIP_IF_ZERO
                            && fileRdData == 8'hFF;
   sequence sStall; !instReady ##1 instReady; endsequence
   sequence sKept; $stable(zeroFlag) && $stable(carryFlag); endsequence
   AST_BRANCH_PC: assert property (
      ex && op == OP_UNCONDITIONAL_BRANCH |=> programCounter ==
      {$past(programCounterHighLatch[6:3]), $past(instr.literal)})
      else $error("branch target wrong");
   AST_BRANCH_STALL: assert property (
      ex && op == OP_UNCONDITIONAL_BRANCH |=> sKept ##0 sStall)
      else $error("branch timing or flags wrong");
   AST_SKIP_FLAGS: assert property (
      ex && op == OP_INCREMENT_SKIP_IF_ZERO |=> sKept)
      else $error("skip increment touched flags");
   AST_SKIP_NOP: assert property (
      tk && skipQ |=> !fileWr.en && $stable(workRegister)
      && programCounter == $past(programCounter) + CNT_ONE)
      else $error("skipped instruction executed");
   AST_INC_ZERO: assert property (
      ex && op == OP_INCREMENT |=> $stable(carryFlag)
      && zeroFlag == ($past(fileRdData) == 8'hFF))
      else $error("increment flags wrong");
   AST_OR_LIT: assert property (
      ex && op == OP_OR_LITERAL_INTO_WORK |=> zeroFlag == !(|workRegister)
      && workRegister == ($past(workRegister) | $past(instr.literal[7:0])))
      else $error("or literal wrong");
   AST_SHIFT: assert property (
      ex && op == OP_LOGICAL_SHIFT_LEFT |=> carryFlag == $past(fileRdData[7])
      && zeroFlag == ($past(fileRdData[6:0]) == 7'h00))
      else $error("shift flags wrong");
   AST_DEST: assert property (
      ex && op inside {OP_INCREMENT, OP_INCREMENT_SKIP_IF_ZERO,
      OP_OR_WORK_WITH_REGISTER, OP_LOGICAL_SHIFT_LEFT}
      |=> fileWr.en == $past(instr.destSel)
      && (!fileWr.en || fileWr.addr == $past(instr.fileAddr)))
      else $error("destination wrong");
   AST_ONE_CYCLE: assert property (
      ex && op != OP_UNCONDITIONAL_BRANCH |=> instReady)
      else $error("unexpected stall");
endmodule
bind cx_exec_unit cx_exec_props cx_exec_props_i (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .instValid(instValid),
   .instr(instr), .instReady(instReady), .fileRdData(fileRdData),
   .fileWr(fileWr), .workRegister(workRegister), .zeroFlag(zeroFlag),
   .carryFlag(carryFlag), .programCounter(programCounter),
   .programCounterHighLatch(programCounterHighLatch));

// >>> dv/cx_exec_unit_test.sv
// self-checking bench for the execution unit
module cx_exec_unit_test
   import cx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [LATCH_W-1:0] LATCH_V = 7'h5A;
   logic                  clk_sys, sys_rst, instValid, instReady;
   logic                  zeroFlag, carryFlag;
   cx_axi_req_t           axiReq;
   cx_axi_rsp_t           axiRsp;
   cx_instr_t             instr;
   cx_file_wr_t           fileWr;
   logic [FADDR_W-1:0]    fileRdAddr;
   logic [DATA_W-1:0]     fileRdData, workRegister;
   logic [CNT_W-1:0]      programCounter, expPc;
   logic [LATCH_W-1:0]    programCounterHighLatch;
   logic [AXI_DATA_W-1:0] rd;
   logic [1:0]            rsp;
   int                    nFail, checked;
   cx_exec_unit cx_exec_unit_i (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .axiReq(axiReq),
      .axiRsp(axiRsp), .instValid(instValid), .instr(instr),
      .instReady(instReady), .fileRdAddr(fileRdAddr),
      .fileRdData(fileRdData), .fileWr(fileWr),
      .workRegister(workRegister), .zeroFlag(zeroFlag),
      .carryFlag(carryFlag), .programCounter(programCounter),
      .programCounterHighLatch(programCounterHighLatch));
   cx_regfile_model cx_regfile_model_i (.clk_sys(clk_sys),
      .rdAddr(fileRdAddr), .rdData(fileRdData), .wr(fileWr));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         nFail++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
      end
   endtask
   task automatic testDone();
      if (nFail == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= a;
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= d;
      axiReq.wstrb <= 4'hF;
      do begin
         @(posedge clk_sys);
         if (aw && axiRsp.awready) begin
            aw = 1'b0;
            axiReq.awvalid <= 1'b0;
         end
         if (w && axiRsp.wready) begin
            w = 1'b0;
            axiReq.wvalid <= 1'b0;
         end
      end while (aw || w || axiRsp.bvalid !== 1'b1);
      rsp = axiRsp.bresp;
   endtask
   task automatic axr(input logic [7:0] a);
      logic ar;
      ar = 1'b1;
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= a;
      do begin
         @(posedge clk_sys);
         if (ar && axiRsp.arready) begin
            ar = 1'b0;
            axiReq.arvalid <= 1'b0;
         end
      end while (ar || axiRsp.rvalid !== 1'b1);
      rd = axiRsp.rdata;
      rsp = axiRsp.rresp;
   endtask
   task automatic ex(input cx_op_t op, input logic [6:0] a,
                     input logic d, input logic [10:0] k);
      @(posedge clk_sys);
      instValid <= 1'b1;
      instr <= '{op, a, d, k};
      expPc = (op == OP_UNCONDITIONAL_BRANCH) ? {LATCH_V[6:3], k}
                                                : expPc + CNT_ONE;
      do @(posedge clk_sys); while (instReady !== 1'b1);
      instValid <= 1'b0;
      @(negedge clk_sys);
      chk(programCounter, expPc);
   endtask
   task automatic ck(input logic [7:0] w, input logic z, input logic c);
      chk(workRegister, w);
      chk(zeroFlag, z);
      chk(carryFlag, c);
   endtask
   initial begin
      sys_rst = 1'b1;
      axiReq = '0;
      axiReq.bready = 1'b1;
      axiReq.rready = 1'b1;
      instValid = 1'b0;
      instr = '0;
      expPc = '0;
      nFail = 0;
      checked = 0;
      cx_regfile_model_i.mem[5] = 8'h40;
      cx_regfile_model_i.mem[9] = 8'h04;
      cx_regfile_model_i.mem[127] = 8'hFF;
      cx_regfile_model_i.mem[6] = 8'h81;
      cx_regfile_model_i.mem[7] = 8'h80;
      cx_regfile_model_i.mem[8] = 8'hFF;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 4; i++) begin
         axr(8'(4 * i));
         chk(rd, 32'h0);
         chk(rsp, RESP_OKAY);
      end
      axw(OFS_HIGH_LATCH, {25'h0, LATCH_V});
      chk(rsp, RESP_OKAY);
      axr(OFS_HIGH_LATCH);
      chk(rd, {25'h0, LATCH_V});
      axw(8'h10, 32'h1);
      chk(rsp, RESP_SLVERR);
      axr(8'h10);
      chk(rd, 32'h0);
      chk(rsp, RESP_SLVERR);
      axw(OFS_PROG_COUNT, 32'h123);
      ex(OP_OR_LITERAL_INTO_WORK, 7'h00, 1'b0, 11'h000);
      ck(8'h00, 1'b1, 1'b0);
      ex(OP_OR_LITERAL_INTO_WORK, 7'h00, 1'b0, 11'h7A3);
      ck(8'hA3, 1'b0, 1'b0);
      ex(OP_OR_WORK_WITH_REGISTER, 7'h05, 1'b1, 11'h000);
      chk(fileWr, {1'b1, 7'h05, 8'hE3});
      ex(OP_OR_WORK_WITH_REGISTER, 7'h09, 1'b0, 11'h000);
      ck(8'hA7, 1'b0, 1'b0);
      ex(OP_INCREMENT, 7'h7F, 1'b0, 11'h000);
      ck(8'h00, 1'b1, 1'b0);
      ex(OP_LOGICAL_SHIFT_LEFT, 7'h06, 1'b1, 11'h000);
      chk(fileWr, {1'b1, 7'h06, 8'h02});
      ck(8'h00, 1'b0, 1'b1);
      ex(OP_LOGICAL_SHIFT_LEFT, 7'h07, 1'b0, 11'h000);
      ck(8'h00, 1'b1, 1'b1);
      ex(OP_INCREMENT_SKIP_IF_ZERO, 7'h08, 1'b1, 11'h000);
      chk(fileWr, {1'b1, 7'h08, 8'h00});
      ex(OP_OR_LITERAL_INTO_WORK, 7'h00, 1'b0, 11'h0FF);
      ck(8'h00, 1'b1, 1'b1);
      ex(OP_INCREMENT_SKIP_IF_ZERO, 7'h08, 1'b0, 11'h000);
      ck(8'h01, 1'b1, 1'b1);
      ex(OP_OR_LITERAL_INTO_WORK, 7'h00, 1'b0, 11'h010);
      ck(8'h11, 1'b0, 1'b1);
      ex(OP_UNCONDITIONAL_BRANCH, 7'h00, 1'b0, 11'h5A5);
      chk(instReady, 1'b0);
      ex(OP_OR_LITERAL_INTO_WORK, 7'h00, 1'b0, 11'h000);
      ck(8'h11, 1'b0, 1'b1);
      ex(OP_NONE, 7'h00, 1'b0, 11'h000);
      ck(8'h11, 1'b0, 1'b1);
      @(posedge clk_sys);
      axr(OFS_STATUS);
      chk(rd, 32'h1);
      axr(OFS_PROG_COUNT);
      chk(rd, {17'h0, expPc});
      axw(OFS_WORK_REG, 32'h5C);
      chk(rsp, RESP_OKAY);
      chk(workRegister, 8'h5C);
      axw(OFS_STATUS, 32'h4);
      axr(OFS_STATUS);
      chk(rd, 32'h4);
      testDone();
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      nFail++;
      testDone();
   end
endmodule

// >>> dv/cx_regfile_model.sv
// data register file partner, combinational read
module cx_regfile_model
   import cx_pkg::*;
(
   input  wire logic               clk_sys,
   input  wire logic [FADDR_W-1:0] rdAddr,
   output      logic [DATA_W-1:0]  rdData,
   input  wire cx_file_wr_t        wr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [0:127];
   assign rdData = mem[rdAddr];
   always @(posedge clk_sys)
      if (wr.en) mem[wr.addr] <= wr.data;
endmodule

// >>> hdl/cx_exec_unit.sv
// execution unit for increment, or, left shift and branch instructions
module cx_exec_unit
   import cx_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          sys_rst,
   input  wire cx_axi_req_t   axiReq,
   output      cx_axi_rsp_t   axiRsp,
   input  wire logic          instValid,
   input  wire cx_instr_t     instr,
   output      logic          instReady,
   output      logic [FADDR_W-1:0] fileRdAddr,
   input  wire logic [DATA_W-1:0]  fileRdData,
   output      cx_file_wr_t   fileWr,
   output      logic [DATA_W-1:0]  workRegister,
   output      logic          zeroFlag,
   output      logic          carryFlag,
   output      logic [CNT_W-1:0]   programCounter,
   output      logic [LATCH_W-1:0] programCounterHighLatch
);

   cx_state_t s_q;
   cx_state_t s_d;

   function automatic logic isZero(input logic [DATA_W-1:0] v);
      isZero = (v == DATA_ZERO);
   endfunction

   function automatic logic isMapped(input logic [AXI_ADDR_W-1:0] a);
      isMapped = (a == OFS_WORK_REG) || (a == OFS_STATUS) ||
                 (a == OFS_HIGH_LATCH) || (a == OFS_PROG_COUNT);
   endfunction

   function automatic logic [AXI_DATA_W-1:0] statusWord(
      input logic z, input logic c);
      logic [AXI_DATA_W-1:0] v;
      v = '0;
      v[STAT_ZERO_BIT]  = z;
      v[STAT_CARRY_BIT] = c;
      statusWord = v;
   endfunction

   logic                  accept;
   logic                  awFire;
   logic                  wFire;
   logic                  arFire;
   logic [DATA_W-1:0]     src;
   logic [DATA_W-1:0]     result;
   logic [AXI_DATA_W-1:0] rdWord;

   assign instReady  = (s_q.fsm != ST_BRANCH_WAIT);
   assign accept     = instValid && instReady;
   assign fileRdAddr = instr.fileAddr;
   assign src        = fileRdData;

   assign axiRsp.awready = !s_q.awHeld && !s_q.bValid;
   assign axiRsp.wready  = !s_q.wHeld && !s_q.bValid;
   assign axiRsp.bvalid  = s_q.bValid;
   assign axiRsp.bresp   = s_q.bResp;
   assign axiRsp.arready = !s_q.rValid;
   assign axiRsp.rvalid  = s_q.rValid;
   assign axiRsp.rdata   = s_q.rData;
   assign axiRsp.rresp   = s_q.rResp;

   assign awFire = axiReq.awvalid && axiRsp.awready;
   assign wFire  = axiReq.wvalid && axiRsp.wready;
   assign arFire = axiReq.arvalid && axiRsp.arready;

   assign fileWr                  = s_q.fileWr;
   assign workRegister            = s_q.work;
   assign zeroFlag                = s_q.zero;
   assign carryFlag               = s_q.carry;
   assign programCounter          = s_q.progCount;
   assign programCounterHighLatch = s_q.highLatch;

   // read data mux
   always_comb begin
      rdWord = '0;
      case (axiReq.araddr)
         OFS_WORK_REG: begin
            rdWord[DATA_W-1:0] = s_q.work;
         end
         OFS_STATUS: begin
            rdWord = statusWord(s_q.zero, s_q.carry);
         end
         OFS_HIGH_LATCH: begin
            rdWord[LATCH_W-1:0] = s_q.highLatch;
         end
         OFS_PROG_COUNT: begin
            rdWord[CNT_W-1:0] = s_q.progCount;
         end
         default: begin
            rdWord = '0;
         end
      endcase
   end

   always_comb begin
      s_d           = s_q;
      s_d.fileWr.en = 1'b0;
      result        = DATA_ZERO;

      // bus write channels
      if (awFire) begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = axiReq.awaddr;
      end
      if (wFire) begin
         s_d.wHeld = 1'b1;
         s_d.wData = axiReq.wdata;
         s_d.wStrb = axiReq.wstrb;
      end
      if (s_q.awHeld && s_q.wHeld) begin
         s_d.awHeld = 1'b0;
         s_d.wHeld  = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp  = isMapped(s_q.awAddr) ? RESP_OKAY : RESP_SLVERR;
         if (s_q.wStrb[0]) begin
            case (s_q.awAddr)
               OFS_WORK_REG: begin
                  s_d.work = s_q.wData[DATA_W-1:0];
               end
               OFS_STATUS: begin
                  s_d.zero  = s_q.wData[STAT_ZERO_BIT];
                  s_d.carry = s_q.wData[STAT_CARRY_BIT];
               end
               OFS_HIGH_LATCH: begin
                  s_d.highLatch = s_q.wData[LATCH_W-1:0];
               end
               default: begin
                  s_d.bValid = 1'b1;
               end
            endcase
         end
      end
      if (s_q.bValid && axiReq.bready) begin
         s_d.bValid = 1'b0;
      end

      // bus read channel
      if (arFire) begin
         s_d.rValid = 1'b1;
         s_d.rData  = rdWord;
         s_d.rResp  = isMapped(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_q.rValid && axiReq.rready) begin
         s_d.rValid = 1'b0;
      end

      // instruction execution, wins over bus writes
      case (s_q.fsm)
         ST_BRANCH_WAIT: begin
            s_d.fsm = ST_EXEC;
         end
         ST_SKIP_NOP: begin
            if (accept) begin
               s_d.progCount = s_q.progCount + CNT_ONE;
               s_d.fsm       = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (accept) begin
               s_d.progCount = s_q.progCount + CNT_ONE;
               case (instr.op)
                  OP_INCREMENT_SKIP_IF_ZERO: begin
                     result = src + DATA_ONE;
                     if (isZero(result)) begin
                        s_d.fsm = ST_SKIP_NOP;
                     end
                  end
                  OP_INCREMENT: begin
                     result = src + DATA_ONE;
                     s_d.zero = isZero(result);
                  end
                  OP_OR_WORK_WITH_REGISTER: begin
                     result = s_q.work | src;
                     s_d.zero = isZero(result);
                  end
                  OP_LOGICAL_SHIFT_LEFT: begin
                     result = {src[DATA_W-2:0], 1'b0};
                     s_d.carry = src[DATA_W-1];
                     s_d.zero  = isZero(result);
                  end
                  OP_OR_LITERAL_INTO_WORK: begin
                     result = s_q.work | instr.literal[DATA_W-1:0];
                     s_d.work = result;
                     s_d.zero = isZero(result);
                  end
                  OP_UNCONDITIONAL_BRANCH: begin
                     s_d.progCount = {
                        s_q.highLatch[LATCH_HI:LATCH_LO],
                        instr.literal[BRANCH_LO_W-1:0]};
                     s_d.fsm = ST_BRANCH_WAIT;
                  end
                  default: begin
                     result = DATA_ZERO;
                  end
               endcase
               if ((instr.op == OP_INCREMENT_SKIP_IF_ZERO) ||
                   (instr.op == OP_INCREMENT) ||
                   (instr.op == OP_OR_WORK_WITH_REGISTER) ||
                   (instr.op == OP_LOGICAL_SHIFT_LEFT)) begin
                  if (instr.destSel == DEST_WORK) begin
                     s_d.work = result;
                  end else begin
                     s_d.fileWr.en   = 1'b1;
                     s_d.fileWr.addr = instr.fileAddr;
                     s_d.fileWr.data = result;
                  end
               end
            end
         end
         default: begin
            s_d.fsm = ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_q     <= '0;
         s_q.fsm <= ST_EXEC;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// >>> hdl/cx_pkg.sv
// types and constants for the instruction execution unit
package cx_pkg;
   localparam int DATA_W     = 8;
   localparam int FADDR_W    = 7;
   localparam int LIT_W      = 11;
   localparam int CNT_W      = 15;
   localparam int LATCH_W    = 7;
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;
   localparam int AXI_STRB_W = 4;
   localparam int BRANCH_LO_W = 11;
   localparam int LATCH_HI   = 6;
   localparam int LATCH_LO   = 3;
   localparam int STAT_CARRY_BIT = 0;
   localparam int STAT_ZERO_BIT  = 2;
   localparam int BYTE_W     = 8;

   localparam logic [AXI_ADDR_W-1:0] OFS_WORK_REG    = 8'h00;
   localparam logic [AXI_ADDR_W-1:0] OFS_STATUS      = 8'h04;
   localparam logic [AXI_ADDR_W-1:0] OFS_HIGH_LATCH  = 8'h08;
   localparam logic [AXI_ADDR_W-1:0] OFS_PROG_COUNT  = 8'h0C;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic       DEST_WORK   = 1'b0;
   localparam logic       DEST_FILE   = 1'b1;
   localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [CNT_W-1:0]  CNT_ONE   = 15'h0001;

   typedef enum logic [2:0] {
      OP_NONE                      = 3'h0,
      OP_INCREMENT_SKIP_IF_ZERO    = 3'h1,
      OP_INCREMENT                 = 3'h2,
      OP_UNCONDITIONAL_BRANCH      = 3'h3,
      OP_OR_LITERAL_INTO_WORK      = 3'h4,
      OP_OR_WORK_WITH_REGISTER     = 3'h5,
      OP_LOGICAL_SHIFT_LEFT        = 3'h6
   } cx_op_t;

   typedef enum logic [2:0] {
      ST_EXEC        = 3'h1,
      ST_BRANCH_WAIT = 3'h2,
      ST_SKIP_NOP    = 3'h4
   } cx_fsm_t;

   typedef struct packed {
      cx_op_t             op;
      logic [FADDR_W-1:0] fileAddr;
      logic               destSel;
      logic [LIT_W-1:0]   literal;
   } cx_instr_t;

   typedef struct packed {
      logic               en;
      logic [FADDR_W-1:0] addr;
      logic [DATA_W-1:0]  data;
   } cx_file_wr_t;

   typedef struct packed {
      logic                  awvalid;
      logic [AXI_ADDR_W-1:0] awaddr;
      logic                  wvalid;
      logic [AXI_DATA_W-1:0] wdata;
      logic [AXI_STRB_W-1:0] wstrb;
      logic                  bready;
      logic                  arvalid;
      logic [AXI_ADDR_W-1:0] araddr;
      logic                  rready;
   } cx_axi_req_t;

   typedef struct packed {
      logic                  awready;
      logic                  wready;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [AXI_DATA_W-1:0] rdata;
      logic [1:0]            rresp;
   } cx_axi_rsp_t;

   typedef struct packed {
      cx_fsm_t               fsm;
      logic [DATA_W-1:0]     work;
      logic                  zero;
      logic                  carry;
      logic [CNT_W-1:0]      progCount;
      logic [LATCH_W-1:0]    highLatch;
      cx_file_wr_t           fileWr;
      logic                  awHeld;
      logic [AXI_ADDR_W-1:0] awAddr;
      logic                  wHeld;
      logic [AXI_DATA_W-1:0] wData;
      logic [AXI_STRB_W-1:0] wStrb;
      logic                  bValid;
      logic [1:0]            bResp;
      logic                  rValid;
      logic [AXI_DATA_W-1:0] rData;
      logic [1:0]            rResp;
   } cx_state_t;
endpackage
